// ---- logic/ess_defines.svh ----
// constants for the enable and soft-start sequencer
// Summary of operation
// [R1] in shutdown the pulse-width outputs float so both switches stay off
// [R2] stay in shutdown until the logic bias supervisor reports its threshold
// [R3] stay in shutdown until the enable comparator reports its input high
// [R4] stay in shutdown until the driver bias supervisor reports threshold
// [R5] no-load voltage codes force shutdown; any other code allows soft-start
// [R6] after a no-load code wait two phase cycles, then shut down
// [R7] a latched overvoltage shutdown is not cleared by no-load codes
// [R8] the system should not use no-load codes as its on/off switch
// [R9] start soft-start at once when all release conditions hold
// [R10] wait sixteen phase cycles before the reference ramp begins
// [R11] raise the ramp reference one step every sixteen phase cycles
// [R12] while feedback is above the ramp keep both switches off
// [R13] once the ramp passes feedback enable the output drives
// [R14] if feedback stays above the whole ramp enable drives at ramp end
// [R15] after soft-start assert power good while output is in its window
// [R16] power good is pulled low in shutdown, released after soft-start
// [R17] a lost condition returns to shutdown; restart runs the full sequence
// [R18] the ramp step counter stops at the code-selected target; here the target comes from the TARGET register
`ifndef ESS_DEFINES_SVH
`define ESS_DEFINES_SVH

// register byte offsets
`define ESS_ADR_CTRL 8'h00
`define ESS_ADR_TARGET 8'h04
`define ESS_ADR_STATUS 8'h08
`define ESS_ADR_RAMP 8'h0C
`define ESS_ADR_IRQ_STAT 8'h10
`define ESS_ADR_IRQ_MASK 8'h14

// reset values
`define ESS_CTRL_RST 2'h0
`define ESS_TARGET_RST 8'h58
`define ESS_MASK_RST 4'h0

// interrupt bit positions
`define ESS_EV_SHUT 0
`define ESS_EV_START 1
`define ESS_EV_POWER_GOOD_OUTPUT 2
`define ESS_EV_NOLOAD 3
`define ESS_EV_W 4

// timing in phase-clock cycles
`define ESS_DELAY_LAST 5'h0F
`define ESS_STEP_LAST 5'h0F
`define ESS_NOLOAD_CYC 2'h2

// no-load codes
`define ESS_NL6_A 6'h3F
`define ESS_NL6_B 6'h3E
`define ESS_NL5 5'h1F

// synchroniser width: phase, logic, driver, enable, fb, window, ov, code[5:0]
`define ESS_SYNC_W 13

`endif

// ---- logic/ess_pkg.sv ----
// types for the enable and soft-start sequencer
package ess_pkg;
    typedef enum logic [1:0] {
        ESS_SHUT = 2'b00,
        ESS_DELAY = 2'b01,
        ESS_RAMP = 2'b10,
        ESS_REG = 2'b11
    } ess_state_t;

    typedef enum logic [1:0] {
        ESS_MODE_SIX = 2'b00,
        ESS_MODE_FIVE_A = 2'b01,
        ESS_MODE_FIVE_B = 2'b10
    } ess_mode_t;
endpackage : ess_pkg

// ---- logic/ess_sequencer.sv ----
// enable, no-load and soft-start sequencer with wishbone registers
//
// Our own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/10ps
`include "ess_defines.svh"
module ess_sequencer
    import ess_pkg::*;
(
    input wire logic clk_i, // 10 MHz system clock
    input wire logic rst_i, // synchronous reset, high
    input wire logic phase_clk_i, // phase clock pin
    input wire logic logic_bias_ok_i, // logic bias supervisor, high = ok
    input wire logic driver_bias_supply_ok_i, // driver bias supervisor
    input wire logic threshold_enable_input_i, // enable comparator result
    input wire logic feedback_node_above_i, // feedback above ramp reference
    input wire logic vout_in_window_i, // output inside its window
    input wire logic ov_latched_i, // latched overvoltage shutdown
    input wire logic [5:0] processor_voltage_code_i, // voltage code pins
    output logic pwm_oe_o, // pulse-width outputs driven, else floating
    output logic drive_enable_o, // switches allowed to conduct
    output logic ov_level_shutdown_o, // overvoltage trip at shutdown level
    output logic [7:0] ramp_ref_o, // ramp reference in steps
    output logic power_good_output_o, // open-drain data, always low
    output logic power_good_output_oe_o, // high while pulling low
    output logic irq_o, // level interrupt
    input wire logic wb_cyc_i, // wishbone cycle
    input wire logic wb_stb_i, // wishbone strobe
    input wire logic wb_we_i, // wishbone write
    input wire logic [7:0] wb_adr_i, // wishbone byte address
    input wire logic [3:0] wb_sel_i, // wishbone byte selects
    input wire logic [31:0] wb_dat_i, // wishbone write data
    output logic [31:0] wb_dat_o, // wishbone read data
    output logic wb_ack_o // wishbone acknowledge
);

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisation
    logic [`ESS_SYNC_W-1:0] pins_s;
    logic ph_s;
    logic logic_s;
    logic drv_s;
    logic en_s;
    logic fb_s;
    logic win_s;
    logic ov_s;
    logic [5:0] code_s;

    ess_sync u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i({processor_voltage_code_i, ov_latched_i, vout_in_window_i,
                  feedback_node_above_i, threshold_enable_input_i,
                  driver_bias_supply_ok_i, logic_bias_ok_i, phase_clk_i}),
        .sync_o(pins_s)
    );

    assign ph_s = pins_s[0];
    assign logic_s = pins_s[1];
    assign drv_s = pins_s[2];
    assign en_s = pins_s[3];
    assign fb_s = pins_s[4];
    assign win_s = pins_s[5];
    assign ov_s = pins_s[6];
    assign code_s = pins_s[12:7];

    ////////////////////////////////////////////////////////////////////////
    // registers shared by both groups
    ess_state_t state_reg, state_next;
    logic [4:0] cnt_reg, cnt_next;
    logic [7:0] ramp_reg, ramp_next;
    logic drv_reg, drv_next;
    logic [1:0] nl_cnt_reg, nl_cnt_next;
    logic ph_prev_reg;
    logic nl_prev_reg;
    logic pg_reg, pg_next;
    logic [1:0] mode_reg, mode_next;
    logic [7:0] target_reg, target_next;
    logic [`ESS_EV_W-1:0] stat_reg, stat_next;
    logic [`ESS_EV_W-1:0] mask_reg, mask_next;
    logic ack_reg, ack_next;
    logic [31:0] rdat_reg, rdat_next;

    logic phase_edge;
    logic noload;
    logic fast_fail;
    logic cond_ok;
    logic nl_expired;
    logic leave;
    logic [`ESS_EV_W-1:0] ev;

    ////////////////////////////////////////////////////////////////////////
    // release conditions
    always_comb begin
        phase_edge = ph_s & ~ph_prev_reg;
        if (ess_mode_t'(mode_reg) == ESS_MODE_SIX) begin
            noload = (code_s == `ESS_NL6_A) || (code_s == `ESS_NL6_B); // R5
        end else begin
            noload = (code_s[4:0] == `ESS_NL5); // R5
        end
        // bias and enable losses act at once, only no-load codes wait
        fast_fail = ~logic_s | ~drv_s | ~en_s | ov_s; // R2 R3 R4 R7
        cond_ok = ~fast_fail & ~noload; // R9
        nl_expired = (nl_cnt_reg == `ESS_NOLOAD_CYC); // R6
        leave = fast_fail | nl_expired; // R17
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer state machine
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        ramp_next = ramp_reg;
        drv_next = drv_reg;
        nl_cnt_next = nl_cnt_reg;
        if (!noload) begin
            nl_cnt_next = 2'h0;
        end else if (phase_edge && !nl_expired) begin
            nl_cnt_next = nl_cnt_reg + 2'h1; // R6
        end
        case (state_reg)
            ESS_SHUT: begin
                cnt_next = 5'h00;
                ramp_next = 8'h00;
                drv_next = 1'b0;
                if (cond_ok) begin
                    state_next = ESS_DELAY; // R9
                end
            end
            ESS_DELAY: begin
                if (phase_edge) begin
                    if (cnt_reg == `ESS_DELAY_LAST) begin
                        cnt_next = 5'h00;
                        state_next = ESS_RAMP; // R10
                    end else begin
                        cnt_next = cnt_reg + 5'h01;
                    end
                end
            end
            ESS_RAMP: begin
                if (!fb_s) begin
                    drv_next = 1'b1; // R12 R13
                end
                if (ramp_reg >= target_reg) begin
                    drv_next = 1'b1; // R14
                    state_next = ESS_REG;
                end else if (phase_edge) begin
                    if (cnt_reg == `ESS_STEP_LAST) begin
                        cnt_next = 5'h00;
                        ramp_next = ramp_reg + 8'h01; // R11 R18
                    end else begin
                        cnt_next = cnt_reg + 5'h01;
                    end
                end
            end
            ESS_REG: begin
                drv_next = 1'b1;
            end
            default: begin
                state_next = ESS_SHUT;
            end
        endcase
        if (state_reg != ESS_SHUT && leave) begin
            // full restart later, delay included
            state_next = ESS_SHUT; // R17
            cnt_next = 5'h00;
            ramp_next = 8'h00;
            drv_next = 1'b0;
        end
        pg_next = (state_next == ESS_REG) && win_s; // R15 R16
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= ESS_SHUT;
            cnt_reg <= 5'h00;
            ramp_reg <= 8'h00;
            drv_reg <= 1'b0;
            nl_cnt_reg <= 2'h0;
            ph_prev_reg <= 1'b0;
            nl_prev_reg <= 1'b0;
            pg_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            ramp_reg <= ramp_next;
            drv_reg <= drv_next;
            nl_cnt_reg <= nl_cnt_next;
            ph_prev_reg <= ph_s;
            nl_prev_reg <= noload;
            pg_reg <= pg_next;
        end
    end

    assign pwm_oe_o = (state_reg != ESS_SHUT); // R1
    assign drive_enable_o = drv_reg;
    assign ov_level_shutdown_o = (state_reg == ESS_SHUT); // R6
    assign ramp_ref_o = ramp_reg;
    assign power_good_output_o = 1'b0;
    assign power_good_output_oe_o = ~pg_reg; // R16

    ////////////////////////////////////////////////////////////////////////
    // wishbone slave and interrupt registers
    always_comb begin
        ev = '0;
        ev[`ESS_EV_SHUT] = (state_reg != ESS_SHUT) && (state_next == ESS_SHUT);
        ev[`ESS_EV_START] = (state_reg == ESS_SHUT) &&
                            (state_next == ESS_DELAY);
        ev[`ESS_EV_POWER_GOOD_OUTPUT] = pg_next & ~pg_reg;
        ev[`ESS_EV_NOLOAD] = noload & ~nl_prev_reg;
        mode_next = mode_reg;
        target_next = target_reg;
        mask_next = mask_reg;
        stat_next = stat_reg;
        rdat_next = 32'h0000_0000;
        ack_next = wb_cyc_i & wb_stb_i & ~ack_reg;
        if (ack_next && wb_we_i && wb_sel_i[0]) begin
            case (wb_adr_i)
                `ESS_ADR_CTRL: mode_next = wb_dat_i[1:0];
                `ESS_ADR_TARGET: target_next = wb_dat_i[7:0];
                `ESS_ADR_IRQ_STAT: begin
                    stat_next = stat_reg & ~wb_dat_i[`ESS_EV_W-1:0];
                end
                `ESS_ADR_IRQ_MASK: mask_next = wb_dat_i[`ESS_EV_W-1:0];
                default: begin
                end
            endcase
        end
        // a new event beats a clear in the same cycle
        stat_next = stat_next | ev;
        if (ack_next && !wb_we_i) begin
            case (wb_adr_i)
                `ESS_ADR_CTRL: rdat_next = {30'h0, mode_reg};
                `ESS_ADR_TARGET: rdat_next = {24'h0, target_reg};
                `ESS_ADR_STATUS: begin
                    rdat_next = {24'h0, pg_reg, noload, drv_reg,
                                 cond_ok, 2'h0, state_reg};
                end
                `ESS_ADR_RAMP: rdat_next = {24'h0, ramp_reg};
                `ESS_ADR_IRQ_STAT: rdat_next = {28'h0, stat_reg};
                `ESS_ADR_IRQ_MASK: rdat_next = {28'h0, mask_reg};
                default: rdat_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode_reg <= `ESS_CTRL_RST;
            target_reg <= `ESS_TARGET_RST;
            stat_reg <= '0;
            mask_reg <= `ESS_MASK_RST;
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0000_0000;
        end else begin
            mode_reg <= mode_next;
            target_reg <= target_next;
            stat_reg <= stat_next;
            mask_reg <= mask_next;
            ack_reg <= ack_next;
            rdat_reg <= rdat_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdat_reg;
    assign irq_o = |(stat_reg & mask_reg);

    ////////////////////////////////////////////////////////////////////////
    // checks
    shut_floats_a: assert property (@(posedge clk_i) disable iff (rst_i) // R1
        state_reg == ESS_SHUT |-> !pwm_oe_o && !drive_enable_o)
        else $error("outputs driven in shutdown");
    logic_loss_a: assert property (@(posedge clk_i) disable iff (rst_i) // R2
        state_reg != ESS_SHUT && !logic_s |=> state_reg == ESS_SHUT)
        else $error("logic bias loss did not shut down");
    enable_loss_a: assert property (@(posedge clk_i) disable iff (rst_i) // R3
        state_reg == ESS_SHUT && !en_s |=> state_reg == ESS_SHUT)
        else $error("left shutdown with enable low");
    drv_loss_a: assert property (@(posedge clk_i) disable iff (rst_i) // R4
        state_reg != ESS_SHUT && !drv_s |=> state_reg == ESS_SHUT)
        else $error("driver bias loss did not shut down");
    noload_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // R5
        state_reg == ESS_SHUT && noload |=> state_reg == ESS_SHUT)
        else $error("left shutdown on no-load code");
    noload_delay_a: assert property (@(posedge clk_i) disable iff (rst_i) // R6
        state_reg != ESS_SHUT && !fast_fail && noload &&
        nl_cnt_reg < `ESS_NOLOAD_CYC |=> pwm_oe_o)
        else $error("no-load shutdown came early");
    noload_end_a: assert property (@(posedge clk_i) disable iff (rst_i) // R6
        state_reg != ESS_SHUT && nl_cnt_reg == `ESS_NOLOAD_CYC
        |=> ov_level_shutdown_o && !pwm_oe_o)
        else $error("no-load shutdown missing");
    ov_hold_a: assert property (@(posedge clk_i) disable iff (rst_i) // R7
        state_reg == ESS_SHUT && ov_s |=> state_reg == ESS_SHUT)
        else $error("overvoltage shutdown released");
    start_now_a: assert property (@(posedge clk_i) disable iff (rst_i) // R9
        state_reg == ESS_SHUT && cond_ok |=> state_reg == ESS_DELAY)
        else $error("soft-start did not start at once");
    delay_flat_a: assert property (@(posedge clk_i) disable iff (rst_i) // R10
        state_reg == ESS_DELAY |-> ramp_reg == 8'h00 && !drive_enable_o)
        else $error("ramp moved during delay");
    step_rate_a: assert property (@(posedge clk_i) disable iff (rst_i) // R11
        ramp_reg != $past(ramp_reg) && state_reg != ESS_SHUT
        |-> $past(phase_edge) && $past(cnt_reg) == `ESS_STEP_LAST &&
            ramp_reg == $past(ramp_reg) + 8'h01)
        else $error("ramp stepped off schedule");
    fb_above_a: assert property (@(posedge clk_i) disable iff (rst_i) // R12
        state_reg == ESS_RAMP && fb_s && !drive_enable_o &&
        ramp_reg < target_reg |=> !drive_enable_o)
        else $error("drives on while feedback above ramp");
    ramp_pass_a: assert property (@(posedge clk_i) disable iff (rst_i) // R13
        state_reg == ESS_RAMP && !fb_s && !leave |=> drive_enable_o)
        else $error("drives not enabled after ramp passed feedback");
    ramp_end_a: assert property (@(posedge clk_i) disable iff (rst_i) // R14
        state_reg == ESS_REG |-> drive_enable_o)
        else $error("drives off after soft-start");
    power_good_output_src_a: assert property (@(posedge clk_i) disable iff (rst_i) // R15
        state_reg == ESS_REG && win_s && !leave |=> !power_good_output_oe_o)
        else $error("power good not released");
    power_good_output_low_a: assert property (@(posedge clk_i) disable iff (rst_i) // R16
        state_reg != ESS_REG |-> power_good_output_oe_o)
        else $error("power good released before soft-start end");
    restart_seq_a: assert property (@(posedge clk_i) disable iff (rst_i) // R17
        state_reg == ESS_SHUT |=> state_reg inside {ESS_SHUT, ESS_DELAY})
        else $error("restart skipped the delay");
    ramp_cap_a: assert property (@(posedge clk_i) disable iff (rst_i) // R18
        ramp_reg != $past(ramp_reg) && state_reg != ESS_SHUT
        |-> $past(ramp_reg) < $past(target_reg))
        else $error("ramp stepped past target");

endmodule : ess_sequencer

// ---- logic/ess_sync.sv ----
// three-stage pin synchroniser with agreement filter, one lane per bit
`timescale 1ns/10ps
`include "ess_defines.svh"
module ess_sync
    import ess_pkg::*;
(
    input wire logic clk_i, // system clock
    input wire logic rst_i, // synchronous reset
    input wire logic [`ESS_SYNC_W-1:0] async_i, // raw pin levels
    output logic [`ESS_SYNC_W-1:0] sync_o // filtered levels
);
    genvar gi;
    generate
        for (gi = 0; gi < `ESS_SYNC_W; gi++) begin : g_lane
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            logic out_reg;
            logic out_next;
            // stage one feeds stage two only
            always_comb begin
                out_next = out_reg;
                if (s2_reg == s3_reg) begin
                    out_next = s3_reg;
                end
            end
            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    s1_reg <= 1'b0;
                    s2_reg <= 1'b0;
                    s3_reg <= 1'b0;
                    out_reg <= 1'b0;
                end else begin
                    s1_reg <= async_i[gi];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                    out_reg <= out_next;
                end
            end
            assign sync_o[gi] = out_reg;
        end
    endgenerate
endmodule : ess_sync

// ---- tb/ess_stage_model.sv ----
// power stage model: phase clock, output level, feedback and window
`timescale 1ns/10ps
module ess_stage_model (
    input wire logic clk_i, // system clock
    input wire logic rst_i, // synchronous reset
    input wire logic pwm_oe_i, // pulse-width outputs driven
    input wire logic drive_enable_i, // switches may conduct
    input wire logic [7:0] ramp_ref_i, // ramp reference in steps
    input wire logic [7:0] precharge_i, // output level at start
    input wire logic [7:0] target_i, // regulation target
    output logic phase_clk_o, // phase clock
    output logic feedback_node_above_o, // feedback above ramp
    output logic vout_in_window_o // output inside window
);
    logic [1:0] div_reg;
    logic [7:0] vout_reg;
    ////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_reg <= 2'h0;
        end else begin
            div_reg <= div_reg + 2'h1;
        end
        // switches off: output keeps its pre-charge, never sags
        if (!pwm_oe_i) begin
            vout_reg <= precharge_i;
        end else if (drive_enable_i) begin
            vout_reg <= ramp_ref_i;
        end
    end
    // oscillator runs free, four system clocks a phase cycle
    assign phase_clk_o = div_reg[1];
    assign feedback_node_above_o = vout_reg > ramp_ref_i;
    assign vout_in_window_o = drive_enable_i && vout_reg == target_i;
endmodule : ess_stage_model

// ---- tb/test_enable_softstart_sequencer.sv ----
// self-checking bench for the enable and soft-start sequencer
`timescale 1ns/10ps
`include "ess_defines.svh"
module test_enable_softstart_sequencer;
    import ess_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic lb = 1'b0;
    logic db = 1'b0;
    logic en = 1'b0;
    logic ov = 1'b0;
    logic [5:0] code = 6'h00;
    logic [7:0] pre = 8'h00;
    logic [7:0] tgt = 8'h04;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic ph, fba, win, pwm_oe, drv, ovl, pg, pg_oe, irq, ack;
    logic [7:0] ramp;
    logic [31:0] rdat;
    int fails = 0;
    int n_checks = 0;
    always #50 clk_i = ~clk_i;
    ess_sequencer dut (.clk_i(clk_i), .rst_i(rst_i), .phase_clk_i(ph),
        .logic_bias_ok_i(lb), .driver_bias_supply_ok_i(db),
        .threshold_enable_input_i(en), .feedback_node_above_i(fba),
        .vout_in_window_i(win), .ov_latched_i(ov),
        .processor_voltage_code_i(code), .pwm_oe_o(pwm_oe),
        .drive_enable_o(drv), .ov_level_shutdown_o(ovl),
        .ramp_ref_o(ramp), .power_good_output_o(pg),
        .power_good_output_oe_o(pg_oe), .irq_o(irq), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
        .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));
    ess_stage_model stage (.clk_i(clk_i), .rst_i(rst_i), .pwm_oe_i(pwm_oe),
        .drive_enable_i(drv), .ramp_ref_i(ramp), .precharge_i(pre),
        .target_i(tgt), .phase_clk_o(ph), .feedback_node_above_o(fba),
        .vout_in_window_o(win));
    ////////////////////////////////////////////////////////////////////////
    task automatic conclude;
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic bus(input logic w, input logic [7:0] a,
            input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        if (n >= 20) begin
            fails++;
            conclude();
        end
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        check(q[7:0], exp);
    endtask : rdc
    // s: 0 pulse-width enable, 1 power good pull-down, else ramp
    task automatic wait_for(input int s, input logic [7:0] v, output int n);
        logic [7:0] x;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
            case (s)
                0: x = 8'(pwm_oe);
                1: x = 8'(pg_oe);
                default: x = ramp;
            endcase
        end while (x !== v && n < 3000);
        if (n >= 3000) begin
            fails++;
            conclude();
        end
    endtask : wait_for
    task automatic setc(input logic l, input logic d, input logic e);
        @(posedge clk_i);
        lb <= l;
        db <= d;
        en <= e;
    endtask : setc
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        check({2'h0, pg, pwm_oe, ovl, pg_oe, drv, irq}, 8'h0C);
        rdc(`ESS_ADR_CTRL, 8'h00);
        rdc(`ESS_ADR_TARGET, 8'h58);
        rdc(`ESS_ADR_IRQ_MASK, 8'h00);
        rdc(`ESS_ADR_IRQ_STAT, 8'h00);
        wr(8'h1C, 32'hFF);
        rdc(8'h1C, 8'h00);
        wr(`ESS_ADR_RAMP, 32'h7);
        rdc(`ESS_ADR_RAMP, 8'h00);
        wr(`ESS_ADR_TARGET, {24'h0, tgt});
        rdc(`ESS_ADR_TARGET, tgt);
    endtask : t_reset
    task automatic t_hold;
        for (int i = 0; i < 3; i++) begin
            setc(i != 0, i != 1, i != 2);
            repeat (60) @(posedge clk_i);
            check(8'(pwm_oe), 8'h00);
        end
    endtask : t_hold
    task automatic t_start(input logic [7:0] p);
        int n;
        @(posedge clk_i);
        pre <= p;
        setc(1'b1, 1'b1, 1'b1);
        wait_for(0, 8'h01, n);
        check(8'(n < 10), 8'h01);
        wait_for(2, 8'h01, n);
        check(8'(n > 122 && n < 134), 8'h01);
        check(8'(drv), 8'(p == 0));
        wait_for(2, 8'h02, n);
        check(8'(n), 8'h40);
        check(8'(drv), 8'(p < 2));
        wait_for(2, tgt, n);
        check(8'(drv), 8'(p < tgt));
        wait_for(1, 8'h00, n);
        check(8'(drv), 8'h01);
        repeat (150) @(posedge clk_i);
        check(ramp, tgt);
        rdc(`ESS_ADR_STATUS, 8'hB3);
        setc(1'b1, 1'b1, 1'b0);
        wait_for(0, 8'h00, n);
        check({5'h0, pg_oe, ovl, drv}, 8'h06);
    endtask : t_start
    task automatic t_irq;
        check(8'(irq), 8'h00);
        rdc(`ESS_ADR_IRQ_STAT, 8'h07);
        wr(`ESS_ADR_IRQ_MASK, 32'h1);
        check(8'(irq), 8'h01);
        wr(`ESS_ADR_IRQ_STAT, 32'h1);
        check(8'(irq), 8'h00);
        rdc(`ESS_ADR_IRQ_STAT, 8'h06);
        wr(`ESS_ADR_IRQ_STAT, 32'h6);
        rdc(`ESS_ADR_IRQ_STAT, 8'h00);
    endtask : t_irq
    // {mode, code}; the last two are ordinary codes in their mode
    task automatic t_noload;
        logic [7:0] tab [6] = '{8'h3F, 8'h3E, 8'h5F, 8'h9F, 8'h1F, 8'h7E};
        int n;
        for (int i = 0; i < 6; i++) begin
            wr(`ESS_ADR_CTRL, {30'h0, tab[i][7:6]});
            setc(1'b1, 1'b1, 1'b1);
            wait_for(0, 8'h01, n);
            code <= tab[i][5:0];
            repeat (5) @(posedge clk_i);
            check(8'(pwm_oe), 8'h01);
            repeat (25) @(posedge clk_i);
            check({6'h0, pwm_oe, ovl}, i < 4 ? 8'h01 : 8'h02);
            code <= 6'h00;
            wait_for(0, 8'h01, n);
            setc(1'b1, 1'b1, 1'b0);
            wait_for(0, 8'h00, n);
        end
    endtask : t_noload
    task automatic t_ov;
        int n;
        setc(1'b1, 1'b1, 1'b1);
        wait_for(0, 8'h01, n);
        ov <= 1'b1;
        wait_for(0, 8'h00, n);
        code <= 6'h3F;
        repeat (30) @(posedge clk_i);
        code <= 6'h00;
        repeat (60) @(posedge clk_i);
        check(8'(pwm_oe), 8'h00);
        ov <= 1'b0;
        wait_for(0, 8'h01, n);
        setc(1'b1, 1'b1, 1'b0);
    endtask : t_ov
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_reset();
        t_hold();
        t_start(8'h00);
        t_irq();
        t_start(8'h02);
        t_start(8'h0A);
        t_noload();
        t_ov();
        conclude();
    end
endmodule : test_enable_softstart_sequencer
